/* File: rtl/rtcbcd_pkg.sv */
// Purpose: constants shared by the bcd time and calendar counter bank
// Assumes: one 10 MHz clock; the serial bus slave sits outside and drives byte strobes
// Notes: offsets are register pointer values, not byte addresses of a public bus
package rtcbcd_pkg;
    // register pointer values
    localparam logic [3:0] OFF_SECONDS = 4'h2;
    localparam logic [3:0] OFF_MINUTES = 4'h3;
    localparam logic [3:0] OFF_HOURS = 4'h4;
    localparam logic [3:0] OFF_DAYS = 4'h5;
    localparam logic [3:0] OFF_WEEKDAY = 4'h6;
    localparam logic [3:0] OFF_MONTH = 4'h7;
    localparam logic [3:0] OFF_YEAR = 4'h8;
    // field positions
    localparam int FLAG_BIT = 7;
    localparam int CENTURY_BIT = 7;
    // reset values
    localparam logic [7:0] RST_SECONDS = 8'h00;
    localparam logic [7:0] RST_MINUTES = 8'h00;
    localparam logic [7:0] RST_HOURS = 8'h00;
    localparam logic [7:0] RST_DAYS = 8'h01;
    localparam logic [7:0] RST_WEEKDAY = 8'h00;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic RST_CENTURY = 1'b0;
    localparam logic RST_FLAG = 1'b1;
    // bcd limits of the carry chain
    localparam logic [7:0] LAST_SECOND = 8'h59;
    localparam logic [7:0] LAST_MINUTE = 8'h59;
    localparam logic [7:0] LAST_HOUR = 8'h23;
    localparam logic [7:0] LAST_MONTH = 8'h12;
    localparam logic [7:0] LAST_YEAR = 8'h99;
    localparam logic [7:0] LAST_WEEKDAY = 8'h06;
    localparam logic [7:0] FEBRUARY = 8'h02;
    // timing: tick period in ns and clock period in ns
    localparam longint TICK_PERIOD_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 100;
    localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
endpackage

/* File: rtl/rtcbcd_tick_div.sv */
// Purpose: divides the system clock down to a one-cycle 1 Hz tick enable
// Assumes: clear input is a synchronous level
// Notes: the count restarts from zero whenever clear is high
`timescale 1ns/100ps
`default_nettype none
module rtcbcd_tick_div
    import rtcbcd_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    output logic tick_out
);
    // cycle counter and registered tick
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    // next count; wraps at CYCLES-1 and emits one pulse there
    always_comb
    begin
        cnt_next = cnt_reg + 32'h1;
        tick_next = 1'b0;
        if (clear_in)
        begin
            // halted chain held at zero, no tick leaves
            cnt_next = 32'h0;
        end
        else if (cnt_reg == 32'(CYCLES - 1))
        begin
            cnt_next = 32'h0;
            tick_next = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;
endmodule
`default_nettype wire

/* File: rtl/rtcbcd_counters.sv */
// Purpose: bcd seconds to years counter bank with integrity flag and byte register port
// Assumes: an outside serial bus slave frames accesses and issues byte strobes
// Notes: pointer values outside 02h..08h read as zero and ignore writes
// Notes: a byte write beats the carry for the byte that it touches
`timescale 1ns/100ps
`default_nettype none
module rtcbcd_counters
    import rtcbcd_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic halt_in,
    input wire logic supply_low_in,
    input wire logic osc_stopped_in,
    input wire logic access_active_in,
    input wire logic ptr_load_in,
    input wire logic [7:0] ptr_data_in,
    input wire logic wr_stb_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_stb_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic integrity_lost_flag_out,
    output logic tick_out
);
    // time and calendar state, each field held as its full 8-bit bcd byte; century and flag are single bits
    // writes store only field bits, but a binary step of invalid bcd can carry into higher ones
    logic [7:0] sec_reg;
    logic [7:0] sec_next;
    logic [7:0] min_reg;
    logic [7:0] min_next;
    logic [7:0] hour_reg;
    logic [7:0] hour_next;
    logic [7:0] day_reg;
    logic [7:0] day_next;
    logic [7:0] wday_reg;
    logic [7:0] wday_next;
    logic [7:0] mon_reg;
    logic [7:0] mon_next;
    logic [7:0] year_reg;
    logic [7:0] year_next;
    logic century_reg;
    logic century_next;
    logic integrity_lost_flag_reg;
    logic integrity_lost_flag_next;
    // held tick and register pointer
    // one held tick only; more ticks inside one access collapse into it
    logic pend_reg;
    logic pend_next;
    logic [3:0] ptr_reg;
    logic [3:0] ptr_next;
    // read port
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    // divider tick and carry helpers
    logic tick;
    logic do_inc;
    logic [7:0] last_day;
    logic [4:0] year_mod;

    // bcd increment of one byte; wraps to first after last
    // invalid bcd is stepped as binary with no correction, by choice
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
        logic [7:0] r;
        r = v + 8'h01;
        // the range end outranks the digit carry
        if (v == last)
        begin
            r = first;
        end
        else if (v[3:0] == 4'h9)
        begin
            // units roll over into the tens digit
            r = {v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    // halt is a level, so the chain sits at zero while it is high
    // halt clears divider
    rtcbcd_tick_div #(
        .CYCLES(TICK_CYCLES_P)
    ) u_div (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(halt_in),
        .tick_out(tick)
    );

    // thirty-day months listed, february by leap test, others thirty-one
    // the century bit lives apart, so the month compare is exact
    // leap year test; 10 = 2 mod 4 so tens*2 + units decides
    always_comb
    begin
        year_mod = 5'({year_reg[7:4], 1'b0}) + 5'(year_reg[3:0]);
        case (mon_reg)
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            FEBRUARY: last_day = (year_mod[1:0] == 2'b00) ? 8'h29 : 8'h28;
            default: last_day = 8'h31;
        endcase
    end

    // pending tick and increment request
    // halt never drops a held tick; it only stops fresh ones
    always_comb
    begin
        pend_next = pend_reg;
        do_inc = 1'b0;
        if (access_active_in)
        begin
            if (tick)
            begin
                // a second tick in the same access is lost on purpose
                pend_next = 1'b1;
            end
        end
        else if (tick || pend_reg)
        begin
            // apply held tick; a tick and a held one together give one step
            do_inc = 1'b1;
            pend_next = 1'b0;
        end
    end

    // carry chain, then byte writes, then flag sources
    // order matters: a write overrides the step, a fault overrides the write
    always_comb
    begin
        sec_next = sec_reg;
        min_next = min_reg;
        hour_next = hour_reg;
        day_next = day_reg;
        wday_next = wday_reg;
        mon_next = mon_reg;
        year_next = year_reg;
        century_next = century_reg;
        integrity_lost_flag_next = integrity_lost_flag_reg;
        if (do_inc)
        begin
            sec_next = bcd_inc(sec_reg, LAST_SECOND, RST_SECONDS);
            if (sec_reg == LAST_SECOND)
            begin
                min_next = bcd_inc(min_reg, LAST_MINUTE, RST_MINUTES);
                if (min_reg == LAST_MINUTE)
                begin
                    hour_next = bcd_inc(hour_reg, LAST_HOUR, RST_HOURS);
                    if (hour_reg == LAST_HOUR)
                    begin
                        day_next = bcd_inc(day_reg, last_day, RST_DAYS);
                        wday_next = bcd_inc(wday_reg, LAST_WEEKDAY, RST_WEEKDAY);
                        if (day_reg == last_day)
                        begin
                            mon_next = bcd_inc(mon_reg, LAST_MONTH, RST_MONTH);
                            if (mon_reg == LAST_MONTH)
                            begin
                                year_next = bcd_inc(year_reg, LAST_YEAR, RST_YEAR);
                                if (year_reg == LAST_YEAR)
                                begin
                                    century_next = ~century_reg;
                                end
                            end
                        end
                    end
                end
            end
        end
        // writes leave unused bits clear; only a step of invalid bcd can set them
        if (wr_stb_in)
        begin
            case (ptr_reg)
                OFF_SECONDS:
                begin
                    sec_next = {1'b0, wr_data_in[6:0]};
                    integrity_lost_flag_next = wr_data_in[FLAG_BIT];
                end
                OFF_MINUTES: min_next = {1'b0, wr_data_in[6:0]};
                OFF_HOURS: hour_next = {2'b00, wr_data_in[5:0]};
                OFF_DAYS: day_next = {2'b00, wr_data_in[5:0]};
                OFF_WEEKDAY: wday_next = {5'h00, wr_data_in[2:0]};
                OFF_MONTH:
                begin
                    mon_next = {3'b000, wr_data_in[4:0]};
                    century_next = wr_data_in[CENTURY_BIT];
                end
                OFF_YEAR: year_next = wr_data_in;
                default:
                begin
                    // other pointer values belong elsewhere
                    // control, alarm and timer places are served outside this bank
                end
            endcase
        end
        // a clearing write and a fault in one cycle leave the flag set
        // set wins over clear
        if (supply_low_in || osc_stopped_in)
        begin
            integrity_lost_flag_next = 1'b1;
        end
    end

    // pointer and read data
    // unmapped pointers read as zero but still advance
    // the pointer is four bits and wraps from f back to 0
    // read data holds its last value between strobes
    always_comb
    begin
        ptr_next = ptr_reg;
        // one valid pulse per strobe, one cycle later
        rd_valid_next = rd_stb_in;
        rd_data_next = rd_data_reg;
        if (rd_stb_in)
        begin
            case (ptr_reg)
                OFF_SECONDS: rd_data_next = {integrity_lost_flag_reg, sec_reg[6:0]};
                OFF_MINUTES: rd_data_next = min_reg;
                OFF_HOURS: rd_data_next = hour_reg;
                OFF_DAYS: rd_data_next = day_reg;
                OFF_WEEKDAY: rd_data_next = wday_reg;
                OFF_MONTH: rd_data_next = {century_reg, mon_reg[6:0]};
                OFF_YEAR: rd_data_next = year_reg;
                default: rd_data_next = 8'h00;
            endcase
        end
        if (ptr_load_in)
        begin
            // a fresh pointer outranks a same-cycle data byte
            ptr_next = ptr_data_in[3:0];
        end
        else if (rd_stb_in || wr_stb_in)
        begin
            ptr_next = ptr_reg + 4'h1;
        end
    end

    // registers only
    // synchronous reset; every time, calendar and flag reset value is a package constant
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            sec_reg <= RST_SECONDS;
            min_reg <= RST_MINUTES;
            hour_reg <= RST_HOURS;
            day_reg <= RST_DAYS;
            wday_reg <= RST_WEEKDAY;
            mon_reg <= RST_MONTH;
            year_reg <= RST_YEAR;
            century_reg <= RST_CENTURY;
            integrity_lost_flag_reg <= RST_FLAG;
            pend_reg <= 1'b0;
            ptr_reg <= 4'h0;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            sec_reg <= sec_next;
            min_reg <= min_next;
            hour_reg <= hour_next;
            day_reg <= day_next;
            wday_reg <= wday_next;
            mon_reg <= mon_next;
            year_reg <= year_next;
            century_reg <= century_next;
            integrity_lost_flag_reg <= integrity_lost_flag_next;
            pend_reg <= pend_next;
            ptr_reg <= ptr_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // outputs straight from flops (tick is the divider's flop)
    // tick leaves the block so the host side can watch the divider run
    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign integrity_lost_flag_out = integrity_lost_flag_reg;
    assign tick_out = tick;
endmodule
`default_nettype wire

/* File: tb/rtcbcd_counters_assertions.sv */
// Purpose: port assertions for the bcd time counter bank
// Assumes: one clock domain, synchronous active low reset
// Notes: tick gap is judged only between ticks with no halt in between
`timescale 1ns/100ps
`default_nettype none
module rtcbcd_counters_chk
#(
    parameter int TICK_CYCLES_P = 10000000
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic halt_in,
    input wire logic supply_low_in,
    input wire logic osc_stopped_in,
    input wire logic wr_stb_in,
    input wire logic rd_stb_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic integrity_lost_flag_out,
    input wire logic tick_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic [31:0] gap_reg; // cycles since the last tick
    logic armed_reg; // a tick was seen with no halt since
    // halt restarts the divider, so a gap only counts after a free tick
    always_ff @(posedge sys_clk_in)
        gap_reg <= (!rst_n_in || halt_in || tick_out) ? 32'h0 : gap_reg + 32'h1;
    always_ff @(posedge sys_clk_in)
        armed_reg <= (!rst_n_in || halt_in) ? 1'b0 : (armed_reg || tick_out);
    property p_rd_answer; rd_stb_in |=> rd_valid_out; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered");
    property p_rd_quiet; !rd_stb_in |=> !rd_valid_out; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("valid without strobe");
    property p_rd_hold; !rd_stb_in |=> $stable(rd_data_out); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_flag_start; $rose(rst_n_in) |-> integrity_lost_flag_out; endproperty
    a_flag_start: assert property (p_flag_start) else $error("flag low at start");
    property p_flag_set; supply_low_in || osc_stopped_in |=> integrity_lost_flag_out; endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_flag_keep; integrity_lost_flag_out && !wr_stb_in |=> integrity_lost_flag_out; endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag cleared alone");
    property p_tick_pulse; tick_out |=> !tick_out; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
    property p_tick_gap; tick_out && armed_reg |-> gap_reg == 32'(TICK_CYCLES_P - 1); endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
    property p_halt_still; halt_in [*3] |-> !tick_out; endproperty
    a_halt_still: assert property (p_halt_still) else $error("tick while halted");
endmodule
bind rtcbcd_counters rtcbcd_counters_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_chk (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .halt_in(halt_in),
    .supply_low_in(supply_low_in), .osc_stopped_in(osc_stopped_in), .wr_stb_in(wr_stb_in),
    .rd_stb_in(rd_stb_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .integrity_lost_flag_out(integrity_lost_flag_out), .tick_out(tick_out));
`default_nettype wire

/* File: tb/rtcbcd_master_model.sv */
// Purpose: bus master model driving the byte port of the counter bank
// Assumes: every request changes just after a falling edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module rtcbcd_master_model
(
    input wire logic sys_clk_in,
    output logic access_active_out,
    output logic ptr_load_out,
    output logic [7:0] ptr_data_out,
    output logic wr_stb_out,
    output logic [7:0] wr_data_out,
    output logic rd_stb_out
);
    initial
    begin
        access_active_out = 1'b0;
        {ptr_load_out, wr_stb_out, rd_stb_out} = 3'h0;
        ptr_data_out = 8'h00;
        wr_data_out = 8'h00;
    end
    // one byte slot of an access; the access stays open
    task automatic op(input logic l, input logic w, input logic r, input logic [7:0] d);
        @(negedge sys_clk_in);
        access_active_out = 1'b1;
        {ptr_load_out, wr_stb_out, rd_stb_out} = {l, w, r};
        ptr_data_out = d;
        wr_data_out = d;
    endtask
    // access closed well inside one tick
    task automatic idle();
        op(1'b0, 1'b0, 1'b0, ~wr_data_out);
        @(negedge sys_clk_in);
        access_active_out = 1'b0;
    endtask
    // pointer 02h then seven bytes in one go
    task automatic write7(input logic [7:0] v[7]);
        op(1'b1, 1'b0, 1'b0, 8'h02);
        foreach (v[i])
            op(1'b0, 1'b1, 1'b0, v[i]);
        idle();
    endtask
    task automatic read7();
        op(1'b1, 1'b0, 1'b0, 8'h02);
        repeat (7)
            op(1'b0, 1'b0, 1'b1, 8'h00);
        idle();
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the bcd time counter bank
// Assumes: master model owns the byte port, bench owns halt and the fault inputs
// Notes: a short tick keeps the run to a few hundred cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int TICKS = 10; // cycles per tick, shortened
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic halt_in = 1'b1; // high except while a tick is wanted
    logic supply_low_in = 1'b0;
    logic osc_stopped_in = 1'b0;
    logic access_active_in, ptr_load_in, wr_stb_in, rd_stb_in;
    logic [7:0] ptr_data_in, wr_data_in, rd_data_out;
    logic rd_valid_out, integrity_lost_flag_out, tick_out;
    logic [7:0] exp_q[$]; // expected read bytes, oldest first
    logic [7:0] cur[7];
    logic [7:0] yr;
    int err_count = 0;
    int checks = 0;
    int y;
    initial
        forever #50 sys_clk_in = ~sys_clk_in;
    rtcbcd_counters #(.TICK_CYCLES_P(TICKS)) i_rtcbcd_counters (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .halt_in(halt_in),
        .supply_low_in(supply_low_in), .osc_stopped_in(osc_stopped_in),
        .access_active_in(access_active_in), .ptr_load_in(ptr_load_in),
        .ptr_data_in(ptr_data_in), .wr_stb_in(wr_stb_in), .wr_data_in(wr_data_in),
        .rd_stb_in(rd_stb_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .integrity_lost_flag_out(integrity_lost_flag_out), .tick_out(tick_out));
    rtcbcd_master_model i_rtcbcd_master_model (
        .sys_clk_in(sys_clk_in), .access_active_out(access_active_in),
        .ptr_load_out(ptr_load_in), .ptr_data_out(ptr_data_in), .wr_stb_out(wr_stb_in),
        .wr_data_out(wr_data_in), .rd_stb_out(rd_stb_in));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic op(input logic l, input logic w, input logic r, input logic [7:0] d);
        i_rtcbcd_master_model.op(l, w, r, d);
    endtask
    // note seven expected bytes, then read them back in one access
    task automatic rd7(input logic [7:0] v[7]);
        foreach (v[i])
            exp_q.push_back(v[i]);
        i_rtcbcd_master_model.read7();
    endtask
    // let cnt ticks through back to back, bounded wait for each
    task automatic run_tick(input int cnt);
        int n;
        halt_in = 1'b0;
        for (int t = 0; t < cnt; t++)
        begin
            n = 0;
            while (tick_out !== 1'b1 && n < 4 * TICKS)
            begin
                @(negedge sys_clk_in);
                n++;
            end
            // halt only after the last tick, so the divider runs freely between
            if (t == cnt - 1)
                halt_in = 1'b1;
            chk("tick_out", {7'h0, tick_out}, 8'h01);
            @(negedge sys_clk_in);
        end
    endtask
    // read answers are compared where they have settled
    always @(negedge sys_clk_in)
    begin
        if (rd_valid_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("rd_valid_out", 8'h01, 8'h00);
            else
                chk("rd_data_out", rd_data_out, exp_q.pop_front());
        end
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        err_count++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'h7c74fb84));
        repeat (16) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        @(negedge sys_clk_in);
        chk("integrity_lost_flag_out", {7'h0, integrity_lost_flag_out}, 8'h01);
        rd7('{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
        // full carry chain at year end, century toggles
        i_rtcbcd_master_model.write7('{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
        run_tick(1);
        rd7('{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00});
        // step from february 28th in a leap year and in the year after
        for (int k = 0; k < 2; k++)
        begin
            y = ($urandom % 25) * 4 + k;
            yr = 8'(((y / 10) << 4) | (y % 10));
            i_rtcbcd_master_model.write7('{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h02, yr});
            run_tick(1);
            cur = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h03, yr};
            if (k == 0)
            begin
                cur[3] = 8'h29;
                cur[5] = 8'h02;
            end
            rd7(cur);
        end
        // counting frozen in a short access that spans one tick, the tick held
        halt_in = 1'b0;
        repeat (TICKS - 4) @(negedge sys_clk_in);
        op(1'b1, 1'b0, 1'b0, 8'h02);
        op(1'b0, 1'b1, 1'b0, 8'h10);
        y = 0;
        while (tick_out !== 1'b1 && y < 4 * TICKS)
        begin
            op(1'b0, 1'b0, 1'b0, 8'h00);
            y++;
        end
        // halt right after the tick, so no second one can come
        halt_in = 1'b1;
        exp_q.push_back(8'h10);
        op(1'b1, 1'b0, 1'b0, 8'h02);
        op(1'b0, 1'b0, 1'b1, 8'h00);
        i_rtcbcd_master_model.idle();
        cur = '{8'h11, 8'h00, 8'h00, 8'h01, 8'h03, 8'h03, yr};
        rd7(cur);
        // two free ticks back to back, seen through the next read
        run_tick(2);
        // either fault source sets the flag, a write clears it
        for (int k = 0; k < 2; k++)
        begin
            supply_low_in = (k == 0);
            osc_stopped_in = (k == 1);
            @(negedge sys_clk_in);
            supply_low_in = 1'b0;
            osc_stopped_in = 1'b0;
            cur[0] = 8'h93;
            rd7(cur);
            cur[0] = 8'h13;
            i_rtcbcd_master_model.write7(cur);
        end
        // pointer walks through unmapped places into seconds
        exp_q = '{8'h00, 8'h00, 8'h13, 8'h00};
        op(1'b1, 1'b0, 1'b0, 8'h00);
        repeat (3) op(1'b0, 1'b0, 1'b1, 8'h00);
        op(1'b1, 1'b0, 1'b0, 8'h09);
        op(1'b0, 1'b1, 1'b0, 8'hff);
        op(1'b1, 1'b0, 1'b0, 8'h09);
        op(1'b0, 1'b0, 1'b1, 8'h00);
        i_rtcbcd_master_model.idle();
        repeat (4) @(negedge sys_clk_in);
        chk("exp_q_left", 8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
